// File: hw/sadc_ctrl.v
`timescale 1ns/1ns
`include "sadc_defines.vh"

// Operation
// - all conversion and calibration timing counts the master clock mclk
// - falling hold input enters hold and starts converting the acquired channel
// - channel select sampled at conversion end picks the next acquired channel
// - at conversion end exactly one tracking output falls, for the next channel
// - sleep low enters quiescent state and keeps calibration results
// - coding select high gives two's complement, low gives offset binary
// - serial data changes on shift clock falling edges; receiver samples rising
// - reset low holds all digital logic in its reset state
// - reset release starts a self calibration of 34,584,480 clock cycles
// - calibration flag stays low during calibration, high once it finishes
// - conversion possible right after sleep returns high, no extra wait
module sadc_ctrl #(
  parameter CAL_CYCLES = `SADC_CAL_CYCLES,
  parameter CONV_CYCLES = `SADC_CONV_CYCLES,
  parameter DATA_W = 16
) (
  input wire mclk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire hold_in,
  input wire lr_sel_in,
  input wire shift_clk_in,
  input wire sleep_n_in,
  input wire code_sel_in,
  input wire factory_test_a,
  input wire factory_test_b,
  input wire factory_test_c,
  input wire factory_test_d,
  input wire [DATA_W-1:0] sample_left_in,
  input wire [DATA_W-1:0] sample_right_in,
  output reg serial_sample_out,
  output reg calibrating_flag,
  output reg tracking_left_out,
  output reg tracking_right_out,
  output reg sample_hold_ctrl_a,
  output reg sample_hold_ctrl_b,
  output reg irq
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [1:0] ST_CAL = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_CONV = 2'h2;
  localparam [1:0] ST_SLEEP = 2'h3;
  localparam [31:0] CAL_LAST_W = CAL_CYCLES - 1;
  localparam [31:0] CONV_LAST_W = CONV_CYCLES - 1;
  localparam [31:0] BITS_LAST_W = DATA_W - 1;
  localparam [`SADC_CAL_W-1:0] CAL_LAST = CAL_LAST_W[`SADC_CAL_W-1:0];
  localparam [`SADC_CONV_W-1:0] CONV_LAST = CONV_LAST_W[`SADC_CONV_W-1:0];
  localparam [4:0] BITS_LAST = BITS_LAST_W[4:0];

  // ----------------------------------------
  // address decode, used by read and write
  // ----------------------------------------
  function [2:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `SADC_OFS_CTRL: reg_sel = `SADC_SEL_CTRL;
        `SADC_OFS_STATUS: reg_sel = `SADC_SEL_STATUS;
        `SADC_OFS_IRQ_STAT: reg_sel = `SADC_SEL_IRQ_STAT;
        `SADC_OFS_IRQ_MASK: reg_sel = `SADC_SEL_IRQ_MASK;
        `SADC_OFS_RESULT: reg_sel = `SADC_SEL_RESULT;
        default: reg_sel = `SADC_SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [`SADC_PIN_W-1:0] pins_raw;
  wire [`SADC_PIN_W-1:0] pins;
  reg [`SADC_PIN_W-1:0] pins_prev_r;

  assign pins_raw = {factory_test_d, factory_test_c, factory_test_b, factory_test_a,
                     code_sel_in, sleep_n_in, shift_clk_in, lr_sel_in, hold_in};

  sadc_sync #(
    .WIDTH(`SADC_PIN_W),
    .INIT(9'h1ff)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .din(pins_raw),
    .dout(pins)
  );

  // previous filtered levels for edge detection
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      pins_prev_r <= 9'h1ff;
    else
      pins_prev_r <= pins;
  end

  wire hold_fall = pins_prev_r[`SADC_PIN_HOLD] & ~pins[`SADC_PIN_HOLD];
  wire sclk_fall = pins_prev_r[`SADC_PIN_SCLK] & ~pins[`SADC_PIN_SCLK];
  wire awake = pins[`SADC_PIN_SLEEP];
  wire test_bad = ~&pins[`SADC_PIN_W-1:`SADC_PIN_TEST];

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  reg [1:0] state_r;
  reg [`SADC_CAL_W-1:0] cal_cnt_r;
  reg [`SADC_CONV_W-1:0] conv_cnt_r;
  reg chan_next_r;
  reg chan_cur_r;
  reg [DATA_W-1:0] held_r;
  reg [DATA_W-1:0] result_r;
  reg [DATA_W-1:0] shift_r;
  reg [4:0] bits_left_r;
  reg shifting_r;
  reg ctrl_en_r;
  reg [`SADC_EV_W-1:0] irq_stat_r;
  reg [`SADC_EV_W-1:0] irq_mask_r;

  wire conv_end = (state_r == ST_CONV) & awake & (conv_cnt_r == CONV_LAST);
  wire cal_end = (state_r == ST_CAL) & (cal_cnt_r == CAL_LAST);
  wire word_end = shifting_r & sclk_fall & (bits_left_r == 5'h0);

  // coding of the held sample
  wire [DATA_W-1:0] coded = pins[`SADC_PIN_CODE] ? (held_r ^ `SADC_SIGN_FLIP) : held_r;

  // ----------------------------------------
  // converter sequencing
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_CAL;
      cal_cnt_r <= {`SADC_CAL_W{1'b0}};
      conv_cnt_r <= {`SADC_CONV_W{1'b0}};
      chan_next_r <= 1'b1;
      chan_cur_r <= 1'b1;
      held_r <= {DATA_W{1'b0}};
      result_r <= {DATA_W{1'b0}};
    end
    else
    begin
      case (state_r)
        ST_CAL:
        begin
          // calibration runs to completion, sleep waits for it
          cal_cnt_r <= cal_cnt_r + 1'b1;
          if (cal_end)
            state_r <= ST_IDLE;
        end
        ST_IDLE:
        begin
          if (!awake)
            state_r <= ST_SLEEP;
          else if (hold_fall && ctrl_en_r)
          begin
            // hold the acquired channel and start converting
            state_r <= ST_CONV;
            conv_cnt_r <= {`SADC_CONV_W{1'b0}};
            chan_cur_r <= chan_next_r;
            held_r <= chan_next_r ? sample_left_in : sample_right_in;
          end
        end
        ST_CONV:
        begin
          if (!awake)
            state_r <= ST_SLEEP;
          else if (conv_end)
          begin
            state_r <= ST_IDLE;
            result_r <= coded;
            chan_next_r <= pins[`SADC_PIN_LR];
          end
          else
            conv_cnt_r <= conv_cnt_r + 1'b1;
        end
        ST_SLEEP:
        begin
          // calibration counters are left untouched while asleep
          if (awake)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_CAL;
      endcase
    end
  end

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      calibrating_flag <= 1'b0;
      tracking_left_out <= 1'b1;
      tracking_right_out <= 1'b1;
      sample_hold_ctrl_a <= 1'b0;
      sample_hold_ctrl_b <= 1'b0;
    end
    else
    begin
      if (cal_end)
        calibrating_flag <= 1'b1;
      if (conv_end)
      begin
        // exactly one tracking line falls, naming the next channel
        tracking_left_out <= ~pins[`SADC_PIN_LR];
        tracking_right_out <= pins[`SADC_PIN_LR];
      end
      else if (state_r == ST_IDLE && awake && hold_fall && ctrl_en_r)
      begin
        tracking_left_out <= 1'b1;
        tracking_right_out <= 1'b1;
      end
      // external holds follow the internal hold per channel
      sample_hold_ctrl_a <= (state_r == ST_CONV) & chan_cur_r;
      sample_hold_ctrl_b <= (state_r == ST_CONV) & ~chan_cur_r;
    end
  end

  // ----------------------------------------
  // serial output shifter
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_r <= {DATA_W{1'b0}};
      bits_left_r <= 5'h0;
      shifting_r <= 1'b0;
      serial_sample_out <= 1'b0;
    end
    else if (conv_end)
    begin
      // new word: msb presented at once
      shift_r <= coded;
      serial_sample_out <= coded[DATA_W-1];
      bits_left_r <= BITS_LAST;
      shifting_r <= 1'b1;
    end
    else if (shifting_r && sclk_fall)
    begin
      if (bits_left_r == 5'h0)
        shifting_r <= 1'b0;
      else
      begin
        // next bit only on a falling shift clock edge
        shift_r <= {shift_r[DATA_W-2:0], 1'b0};
        serial_sample_out <= shift_r[DATA_W-2];
        bits_left_r <= bits_left_r - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire apb_acc = psel & penable;
  wire apb_done = apb_acc & pready;
  wire [2:0] sel = reg_sel(paddr);
  wire wr_en = apb_done & pwrite;
  wire [`SADC_EV_W-1:0] ev = {word_end, cal_end, conv_end};
  wire [`SADC_EV_W-1:0] w1c = (wr_en && sel == `SADC_SEL_IRQ_STAT) ?
                              pwdata[`SADC_EV_W-1:0] : {`SADC_EV_W{1'b0}};
  reg [31:0] rd_val;

  // read mux
  always @*
  begin
    rd_val = 32'h0;
    case (reg_sel(paddr))
      `SADC_SEL_CTRL: rd_val[`SADC_CTRL_EN] = ctrl_en_r;
      `SADC_SEL_STATUS:
      begin
        rd_val[`SADC_ST_CAL_DONE] = calibrating_flag;
        rd_val[`SADC_ST_BUSY] = (state_r == ST_CONV);
        rd_val[`SADC_ST_CHAN_LEFT] = chan_next_r;
        rd_val[`SADC_ST_ASLEEP] = (state_r == ST_SLEEP);
        rd_val[`SADC_ST_SHIFTING] = shifting_r;
        rd_val[`SADC_ST_TEST_BAD] = test_bad;
      end
      `SADC_SEL_IRQ_STAT: rd_val[`SADC_EV_W-1:0] = irq_stat_r;
      `SADC_SEL_IRQ_MASK: rd_val[`SADC_EV_W-1:0] = irq_mask_r;
      `SADC_SEL_RESULT: rd_val[DATA_W-1:0] = result_r;
      default: rd_val = 32'h0;
    endcase
  end

  // one wait state, then answer
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (apb_acc && !pready)
    begin
      pready <= 1'b1;
      pslverr <= (sel == `SADC_SEL_NONE);
      prdata <= pwrite ? 32'h0 : rd_val;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
  end

  // control, mask and sticky status, set beats clear
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_en_r <= `SADC_CTRL_RST;
      irq_mask_r <= `SADC_MASK_RST;
      irq_stat_r <= {`SADC_EV_W{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      if (wr_en && sel == `SADC_SEL_CTRL)
        ctrl_en_r <= pwdata[`SADC_CTRL_EN];
      if (wr_en && sel == `SADC_SEL_IRQ_MASK)
        irq_mask_r <= pwdata[`SADC_EV_W-1:0];
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

// File: hw/sadc_defines.vh
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SADC_OFS_CTRL 8'h00
`define SADC_OFS_STATUS 8'h04
`define SADC_OFS_IRQ_STAT 8'h08
`define SADC_OFS_IRQ_MASK 8'h0c
`define SADC_OFS_RESULT 8'h10

// register select codes
`define SADC_SEL_NONE 3'h0
`define SADC_SEL_CTRL 3'h1
`define SADC_SEL_STATUS 3'h2
`define SADC_SEL_IRQ_STAT 3'h3
`define SADC_SEL_IRQ_MASK 3'h4
`define SADC_SEL_RESULT 3'h5

// ----------------------------------------
// field positions
// ----------------------------------------
`define SADC_CTRL_EN 0
`define SADC_ST_CAL_DONE 0
`define SADC_ST_BUSY 1
`define SADC_ST_CHAN_LEFT 2
`define SADC_ST_ASLEEP 3
`define SADC_ST_SHIFTING 4
`define SADC_ST_TEST_BAD 5
`define SADC_EV_CONV 0
`define SADC_EV_CAL 1
`define SADC_EV_WORD 2
`define SADC_EV_W 3

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SADC_CTRL_RST 1'h1
`define SADC_MASK_RST 3'h0
`define SADC_CAL_CYCLES 34584480
`define SADC_CONV_CYCLES 192
`define SADC_CAL_W 26
`define SADC_CONV_W 8
`define SADC_SIGN_FLIP 16'h8000

// pin synchroniser bit positions
`define SADC_PIN_HOLD 0
`define SADC_PIN_LR 1
`define SADC_PIN_SCLK 2
`define SADC_PIN_SLEEP 3
`define SADC_PIN_CODE 4
`define SADC_PIN_TEST 5
`define SADC_PIN_W 9

`endif

// File: hw/sadc_sync.v
`timescale 1ns/1ns
`include "sadc_defines.vh"

// three-stage pin synchroniser; output follows once stages two and three agree
module sadc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire reset_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  reg [WIDTH-1:0] held_r;
  genvar i;

  // --------------------------------------
  // sampling chain
  // --------------------------------------
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per-bit memory of the last agreed level
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          held_r[i] <= INIT[i];
        else
          held_r[i] <= dout[i];
      end
    end
  endgenerate

  // agreed level shows at once; an extra stage here would push shift data past the rising edge
  always @*
  begin
    dout = (s2_r & s3_r) | (held_r & (s2_r | s3_r));
  end

endmodule

// File: verif/sadc_chk_sva.sv
`timescale 1ns/1ns
// ----------
// port checker
// ----------
module sadc_chk #(
  parameter CAL_CYCLES = 50,
  parameter CONV_CYCLES = 20
) (
  input wire mclk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire calibrating_flag,
  input wire tracking_left_out,
  input wire tracking_right_out,
  input wire sample_hold_ctrl_a,
  input wire sample_hold_ctrl_b
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  wire conv = sample_hold_ctrl_a | sample_hold_ctrl_b;
  logic [31:0] cyc_r;
  logic [31:0] conv_r;
  // clocks since reset release and clocks spent converting
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cyc_r <= 32'h0;
      conv_r <= 32'h0;
    end
    else
    begin
      cyc_r <= cyc_r + 32'h1;
      conv_r <= conv ? conv_r + 32'h1 : 32'h0;
    end
  end
  property p_trk_one;
    tracking_left_out || tracking_right_out;
  endproperty
  a_trk_one: assert property (p_trk_one) else $error("both tracking low");
  property p_trk_end;
    $fell(conv) |-> ##[0:2] (tracking_left_out != tracking_right_out);
  endproperty
  a_trk_end: assert property (p_trk_end) else $error("no tracking fall");
  property p_conv_len;
    $fell(conv) |-> (conv_r >= CONV_CYCLES - 2 && conv_r <= CONV_CYCLES + 1);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length");
  property p_cal_low;
    cyc_r < CAL_CYCLES |-> !calibrating_flag;
  endproperty
  a_cal_low: assert property (p_cal_low) else $error("calibration ended early");
  property p_cal_high;
    cyc_r > CAL_CYCLES + 2 |-> calibrating_flag;
  endproperty
  a_cal_high: assert property (p_cal_high) else $error("calibration late");
  property p_cal_keep;
    calibrating_flag |=> calibrating_flag;
  endproperty
  a_cal_keep: assert property (p_cal_keep) else $error("calibration lost");
  property p_apb_lat;
    $rose(psel && penable) |-> !pready ##1 pready;
  endproperty
  a_apb_lat: assert property (p_apb_lat) else $error("apb answer timing");
  property p_apb_err;
    pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("unmapped not refused");
endmodule

// File: verif/sadc_far.sv
`timescale 1ns/1ns
// ----------
// timing generator and serial capture
// ----------
module sadc_far (
  input wire mclk,
  input wire serial_sample_out,
  output logic hold_in,
  output logic shift_clk_in
);
  // hold and shift clock rest high
  initial
  begin
    hold_in = 1'b1;
    shift_clk_in = 1'b1;
  end
  // hold strobe, low four clocks
  task strobe;
  begin
    @(posedge mclk);
    hold_in <= 1'b0;
    repeat (4) @(posedge mclk);
    hold_in <= 1'b1;
  end
  endtask
  // msb shows first, then 16 falls; bits taken on rises
  task automatic shift(output logic [15:0] w);
    integer i;
  begin
    @(posedge mclk);
    #98;
    w[15] = serial_sample_out;
    for (i = 1; i <= 16; i++)
    begin
      shift_clk_in = 1'b0;
      #400;
      shift_clk_in = 1'b1;
      if (i < 16)
        w[15 - i] = serial_sample_out;
      #400;
    end
  end
  endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ns
`include "sadc_defines.vh"
module tb_top;
  localparam CAL = 50;
  localparam CONV = 20;
  logic mclk, reset_n, psel, penable, pwrite, lr_sel_in, sleep_n_in, code_sel_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, hold_in, shift_clk_in, serial_sample_out, calibrating_flag;
  logic trk_l, trk_r, ssh_a, ssh_b, irq, err, pv;
  logic [15:0] sample_left_in, sample_right_in, word, expw;
  integer fail_count, tests_run, i;
  sadc_ctrl #(.CAL_CYCLES(CAL), .CONV_CYCLES(CONV)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hold_in(hold_in), .lr_sel_in(lr_sel_in), .shift_clk_in(shift_clk_in),
    .sleep_n_in(sleep_n_in), .code_sel_in(code_sel_in),
    .factory_test_a(1'b1), .factory_test_b(1'b1),
    .factory_test_c(1'b1), .factory_test_d(1'b1),
    .sample_left_in(sample_left_in), .sample_right_in(sample_right_in),
    .serial_sample_out(serial_sample_out), .calibrating_flag(calibrating_flag),
    .tracking_left_out(trk_l), .tracking_right_out(trk_r),
    .sample_hold_ctrl_a(ssh_a), .sample_hold_ctrl_b(ssh_b), .irq(irq));
  sadc_far i_far (.mclk(mclk), .serial_sample_out(serial_sample_out), .hold_in(hold_in),
    .shift_clk_in(shift_clk_in));
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task summarize;
  begin
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task hang;
  begin
    $display("ERROR wait expected end seen timeout");
    fail_count++;
    summarize;
  end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
  begin
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
  begin
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20)
      hang;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // bounded wait: 0 converting, 1 tracking fell, 2 calibrated
  task wt(input integer m);
    integer n;
  begin
    n = 0;
    while (n < 300 && (m == 0 ? ssh_a | ssh_b : m == 1 ? ~(trk_l & trk_r) :
      calibrating_flag) !== 1'b1)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 300)
      hang;
  end
  endtask
  task conv;
  begin
    i_far.strobe;
    wt(0);
    wt(1);
  end
  endtask
  task t_cal;
  begin
    chk("trk reset", 2'b11, {trk_l, trk_r});
    @(posedge mclk);
    reset_n <= 1'b1;
    repeat (CAL - 2) @(posedge mclk);
    chk("cal busy", 0, calibrating_flag);
    wt(2);
    $display("test cal done");
  end
  endtask
  task t_regs;
  begin
    apb(0, `SADC_OFS_CTRL, 0);
    chk("ctrl", 1, rd);
    apb(0, `SADC_OFS_STATUS, 0);
    chk("status", 1, rd & 32'h21);
    apb(0, 8'h14, 0);
    chk("unmapped", 1, err);
    apb(0, `SADC_OFS_IRQ_MASK, 0);
    chk("mask", 0, rd);
    apb(1, `SADC_OFS_IRQ_MASK, 1);
    apb(1, `SADC_OFS_IRQ_STAT, 7);
    $display("test regs done");
  end
  endtask
  // every channel and coding pair, words checked serially and by register
  task t_conv;
  begin
    sample_left_in <= 16'h8001;
    sample_right_in <= 16'h7ffe;
    conv;
    i_far.shift(word);
    pv = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      lr_sel_in <= i[1];
      code_sel_in <= i[0];
      conv;
      chk("tracking", i[1] ? 2'b01 : 2'b10, {trk_l, trk_r});
      expw = (pv ? 16'h8001 : 16'h7ffe) ^ (i[0] ? 16'h8000 : 16'h0);
      i_far.shift(word);
      chk("word", expw, word);
      apb(0, `SADC_OFS_RESULT, 0);
      chk("result", expw, rd);
      chk("irq", 1, irq);
      apb(1, `SADC_OFS_IRQ_STAT, 7);
      repeat (3) @(posedge mclk);
      chk("irq clear", 0, irq);
      pv = i[1];
    end
    $display("test conv done");
  end
  endtask
  task t_sleep;
  begin
    lr_sel_in <= 1'b0;
    sleep_n_in <= 1'b0;
    repeat (6) @(posedge mclk);
    apb(0, `SADC_OFS_STATUS, 0);
    chk("asleep", 8, rd & 32'h8);
    i_far.strobe;
    repeat (CONV + 10) @(posedge mclk);
    chk("hold ignored", 2'b01, {trk_l, trk_r});
    sleep_n_in <= 1'b1;
    conv;
    chk("cal kept", 1, calibrating_flag);
    $display("test sleep done");
  end
  endtask
  initial
  begin
    fail_count = 0;
    tests_run = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    lr_sel_in = 1'b1;
    sleep_n_in = 1'b1;
    code_sel_in = 1'b0;
    sample_left_in = 16'h0;
    sample_right_in = 16'h0;
    repeat (5) @(posedge mclk);
    t_cal;
    t_regs;
    t_conv;
    t_sleep;
    summarize;
  end
endmodule
bind sadc_ctrl sadc_chk #(.CAL_CYCLES(CAL_CYCLES), .CONV_CYCLES(CONV_CYCLES)) i_chk (
  .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .calibrating_flag(calibrating_flag),
  .tracking_left_out(tracking_left_out), .tracking_right_out(tracking_right_out),
  .sample_hold_ctrl_a(sample_hold_ctrl_a), .sample_hold_ctrl_b(sample_hold_ctrl_b));
